// ==== rtl/dcvi_pkg.sv ====
// Notes on behaviour
// - Every request drives the lowest line plus the configured level line.
// - Level 7 devices also drive the level 6 line.
// - Request only when a device condition holds and interrupt enable is set.
// - Request lines stay asserted until the request is acknowledged.
// - A non-requesting device passes the acknowledge down the chain.
// - Level 4 watches 5 and 6, level 5 watches 6, level 6 watches 7.
// - With no higher line active, a block flop on the strobe edge withholds the chain.
// - With a higher line active, the requester drops out and forwards the acknowledge.
// - A single-level requester blocks on the strobe edge without checking lines.
// - Strobe and acknowledge together make the winner reply and drive its vector.
// - The vector is settled no later than 125 ns after reply.
// - After strobe release the device drops reply and removes the vector within 100 ns.
// - Reply comes no later than 10 us after the acknowledge arrives.
// - The vector is hardware fixed below octal 001000 and names a word pair.
// - Of the requesters that block, the one nearest the processor on the chain wins.
`default_nettype none
package dcvi_pkg;
   localparam int          CLK_MHZ          = 200;
   localparam int          VEC_SETTLE_NS    = 125;
   localparam int          VEC_SETTLE_CYC   = (VEC_SETTLE_NS * CLK_MHZ) / 1000;
   localparam int          VEC_REMOVE_NS    = 100;
   localparam int          VEC_REMOVE_CYC   = (VEC_REMOVE_NS * CLK_MHZ) / 1000;
   localparam int          REPLY_MAX_US     = 10;
   localparam int          REPLY_MAX_CYC    = REPLY_MAX_US * CLK_MHZ;
   localparam int          REPLY_CYC        = 4;
   localparam int          VEC_W            = 16;
   localparam logic [15:0] VEC_LIMIT        = 16'h0200;
   localparam logic [15:0] VEC_ALIGN_MASK   = 16'h0003;
   localparam logic [1:0]  LVL_4            = 2'h0;
   localparam logic [1:0]  LVL_5            = 2'h1;
   localparam logic [1:0]  LVL_6            = 2'h2;
   localparam logic [1:0]  LVL_7            = 2'h3;
   localparam int          IRQ_W            = 4;
   localparam int          IDX_L4           = 0;
   localparam int          IDX_L5           = 1;
   localparam int          IDX_L6           = 2;
   localparam int          IDX_L7           = 3;
   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_PASS, ST_WON, ST_REPLY, ST_DONE} dcvi_state_t;
endpackage : dcvi_pkg
`default_nettype wire

// ==== rtl/dcvi_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcvi_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   input  wire logic         ce_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_r;
   logic [W-1:0] s2_nxt;
   always_comb begin
      s1_nxt = ce_in ? d_in : s1_r;
      s2_nxt = ce_in ? s1_r : s2_r;
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end
   assign q_out = s2_r;
endmodule : dcvi_sync
`default_nettype wire

// ==== rtl/dcvi_req_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcvi_req_map (
   input  wire logic                        active_in,
   input  wire logic [1:0]                  level_in,
   input  wire logic                        single_level_in,
   input  wire logic [dcvi_pkg::IRQ_W-1:0]  lines_seen_in,
   output logic      [dcvi_pkg::IRQ_W-1:0]  drive_out,
   output logic                             higher_out
);
   always_comb begin
      drive_out = '0;
      higher_out = 1'b0;
      if (active_in) begin
         drive_out[dcvi_pkg::IDX_L4] = 1'b1;
         case (level_in)
            dcvi_pkg::LVL_5: drive_out[dcvi_pkg::IDX_L5] = 1'b1;
            dcvi_pkg::LVL_6: drive_out[dcvi_pkg::IDX_L6] = 1'b1;
            dcvi_pkg::LVL_7: begin
               drive_out[dcvi_pkg::IDX_L6] = 1'b1;
               drive_out[dcvi_pkg::IDX_L7] = 1'b1;
            end
            default: ;
         endcase
      end
      if (!single_level_in) begin
         case (level_in)
            dcvi_pkg::LVL_4: higher_out = lines_seen_in[dcvi_pkg::IDX_L5] | lines_seen_in[dcvi_pkg::IDX_L6];
            dcvi_pkg::LVL_5: higher_out = lines_seen_in[dcvi_pkg::IDX_L6];
            dcvi_pkg::LVL_6: higher_out = lines_seen_in[dcvi_pkg::IDX_L7];
            default:         higher_out = 1'b0;
         endcase
      end
   end
endmodule : dcvi_req_map
`default_nettype wire

// ==== rtl/dcvi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcvi_top #(
   parameter int          REPLY_MAX_CYC_P = dcvi_pkg::REPLY_MAX_CYC,
   parameter logic [15:0] VECTOR_P        = 16'h0100
) (
   input  wire logic                       ref_clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       ce_in,
   input  wire logic                       cond_ready_in,
   input  wire logic                       cond_done_in,
   input  wire logic                       cond_error_in,
   input  wire logic                       int_enable_in,
   input  wire logic [1:0]                 level_in,
   input  wire logic                       single_level_in,
   input  wire logic [dcvi_pkg::IRQ_W-1:0] irq_lines_in,
   input  wire logic                       data_input_strobe_in,
   input  wire logic                       ack_chain_in,
   output logic      [dcvi_pkg::IRQ_W-1:0] irq_line_oe_out,
   output logic                            ack_chain_out,
   output logic                            slave_reply_oe_out,
   output logic      [dcvi_pkg::VEC_W-1:0] dal_out,
   output logic                            dal_oe_out,
   output logic                            reply_late_out
);
   // -----------------------------------------------------------
   // Input synchronisation
   // -----------------------------------------------------------
   logic [dcvi_pkg::IRQ_W-1:0] lines_s;
   logic                       din_s;
   logic                       aki_s;
   dcvi_sync #(.W(dcvi_pkg::IRQ_W + 2)) u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .d_in       ({irq_lines_in, data_input_strobe_in, ack_chain_in}),
      .q_out      ({lines_s, din_s, aki_s})
   );

   // -----------------------------------------------------------
   // Request mapping
   // -----------------------------------------------------------
   logic                       active_s;
   logic [dcvi_pkg::IRQ_W-1:0] drive_s;
   logic                       higher_s;
   dcvi_req_map u_map (
      .active_in       (active_s),
      .level_in        (level_in),
      .single_level_in (single_level_in),
      .lines_seen_in   (lines_s),
      .drive_out       (drive_s),
      .higher_out      (higher_s)
   );

   // -----------------------------------------------------------
   // Interrupt condition
   // -----------------------------------------------------------
   logic                       cond_s;
   always_comb begin
      cond_s = (cond_ready_in | cond_done_in | cond_error_in) & int_enable_in;
   end

   // -----------------------------------------------------------
   // Request and arbitration state
   // -----------------------------------------------------------
   dcvi_pkg::dcvi_state_t      state_r;
   dcvi_pkg::dcvi_state_t      state_nxt;
   logic                       block_r;
   logic                       block_nxt;
   logic                       din_d_r;
   logic                       din_d_nxt;
   logic [15:0]                wait_r;
   logic [15:0]                wait_nxt;
   logic                       din_rise;
   logic                       wins_arb;

   always_comb begin
      din_rise  = din_s & ~din_d_r;
      wins_arb  = single_level_in | ~higher_s;
      state_nxt = state_r;
      block_nxt = block_r;
      din_d_nxt = din_s;
      wait_nxt  = wait_r;
      case (state_r)
         dcvi_pkg::ST_IDLE: begin
            block_nxt = 1'b0;
            if (cond_s) begin
               state_nxt = dcvi_pkg::ST_REQ;
            end
         end
         dcvi_pkg::ST_REQ: begin
            if (din_rise && wins_arb) begin
               block_nxt = 1'b1;
            end else if (!din_s) begin
               block_nxt = 1'b0;
            end
            if (aki_s && din_s) begin
               if (block_r) begin
                  state_nxt = dcvi_pkg::ST_WON;
                  wait_nxt  = 16'h0000;
               end else begin
                  state_nxt = dcvi_pkg::ST_PASS;
               end
            end
         end
         dcvi_pkg::ST_PASS: begin
            if (!din_s) begin
               state_nxt = dcvi_pkg::ST_REQ;
            end
         end
         dcvi_pkg::ST_WON: begin
            wait_nxt = wait_r + 16'h0001;
            if (wait_r == 16'(dcvi_pkg::REPLY_CYC - 1)) begin
               state_nxt = dcvi_pkg::ST_REPLY;
            end
         end
         dcvi_pkg::ST_REPLY: begin
            if (!din_s) begin
               state_nxt = dcvi_pkg::ST_DONE;
            end
         end
         dcvi_pkg::ST_DONE: begin
            // withdraw after the vector is taken
            block_nxt = 1'b0;
            state_nxt = dcvi_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = dcvi_pkg::ST_IDLE;
            block_nxt = 1'b0;
         end
      endcase
      if (!ce_in) begin
         state_nxt = state_r;
         block_nxt = block_r;
         din_d_nxt = din_d_r;
         wait_nxt  = wait_r;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_r <= dcvi_pkg::ST_IDLE;
         block_r <= 1'b0;
         din_d_r <= 1'b0;
         wait_r  <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         block_r <= block_nxt;
         din_d_r <= din_d_nxt;
         wait_r  <= wait_nxt;
      end
   end

   // -----------------------------------------------------------
   // Bus outputs
   // -----------------------------------------------------------
   logic [dcvi_pkg::IRQ_W-1:0] oe_r;
   logic [dcvi_pkg::IRQ_W-1:0] oe_nxt;
   logic                       aco_r;
   logic                       aco_nxt;
   logic                       reply_r;
   logic                       reply_nxt;
   logic [dcvi_pkg::VEC_W-1:0] dal_r;
   logic [dcvi_pkg::VEC_W-1:0] dal_nxt;
   logic                       dal_oe_r;
   logic                       dal_oe_nxt;

   always_comb begin
      active_s   = (state_r == dcvi_pkg::ST_REQ) || (state_r == dcvi_pkg::ST_PASS) ||
                   (state_r == dcvi_pkg::ST_WON) || (state_r == dcvi_pkg::ST_REPLY);
      oe_nxt     = drive_s;
      // pass the acknowledge when not blocking
      aco_nxt    = aki_s & ~block_r & (state_r != dcvi_pkg::ST_WON) & (state_r != dcvi_pkg::ST_REPLY);
      reply_nxt  = (state_nxt == dcvi_pkg::ST_REPLY) & din_s & aki_s;
      dal_nxt    = reply_nxt ? VECTOR_P : '0;
      dal_oe_nxt = reply_nxt;
      if (!ce_in) begin
         oe_nxt     = oe_r;
         aco_nxt    = aco_r;
         reply_nxt  = reply_r;
         dal_nxt    = dal_r;
         dal_oe_nxt = dal_oe_r;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         oe_r     <= '0;
         aco_r    <= 1'b0;
         reply_r  <= 1'b0;
         dal_r    <= '0;
         dal_oe_r <= 1'b0;
      end else begin
         oe_r     <= oe_nxt;
         aco_r    <= aco_nxt;
         reply_r  <= reply_nxt;
         dal_r    <= dal_nxt;
         dal_oe_r <= dal_oe_nxt;
      end
   end

   assign irq_line_oe_out    = oe_r;
   assign ack_chain_out      = aco_r;
   assign slave_reply_oe_out = reply_r;
   assign dal_out            = dal_r;
   assign dal_oe_out         = dal_oe_r;

   // -----------------------------------------------------------
   // Reply deadline watch
   // -----------------------------------------------------------
   logic [15:0]                resp_cnt_r;
   logic [15:0]                resp_cnt_nxt;
   logic                       late_r;
   logic                       late_nxt;

   always_comb begin
      resp_cnt_nxt = (state_r == dcvi_pkg::ST_WON) ? resp_cnt_r + 16'h0001 : 16'h0000;
      late_nxt     = late_r | ((state_r == dcvi_pkg::ST_WON) && (resp_cnt_r >= 16'(REPLY_MAX_CYC_P)));
      if (!ce_in) begin
         resp_cnt_nxt = resp_cnt_r;
         late_nxt     = late_r;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         resp_cnt_r <= 16'h0000;
         late_r     <= 1'b0;
      end else begin
         resp_cnt_r <= resp_cnt_nxt;
         late_r     <= late_nxt;
      end
   end

   assign reply_late_out = late_r;

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   a_lowest_line_on: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      (|irq_line_oe_out) |-> irq_line_oe_out[dcvi_pkg::IDX_L4])
      else $error("request without lowest line");

   a_lvl7_adds_six: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      irq_line_oe_out[dcvi_pkg::IDX_L7] |-> irq_line_oe_out[dcvi_pkg::IDX_L6])
      else $error("level 7 request without level 6 line");

   a_req_needs_cond: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == dcvi_pkg::ST_IDLE) ##1 (state_r == dcvi_pkg::ST_REQ) |->
         $past(int_enable_in) && $past(cond_ready_in | cond_done_in | cond_error_in))
      else $error("request raised without enabled condition");

   a_lines_held: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      ((state_r == dcvi_pkg::ST_REQ) || (state_r == dcvi_pkg::ST_PASS)) &&
         ($past(state_r) != dcvi_pkg::ST_IDLE) |-> (|irq_line_oe_out))
      else $error("request lines dropped before acknowledge");

   a_idle_passes_ack: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_r == dcvi_pkg::ST_IDLE) && aki_s && ce_in |=> ack_chain_out)
      else $error("idle device did not pass acknowledge");

   a_blocked_no_ack: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      $past(block_r) && $past(ce_in) |-> !ack_chain_out)
      else $error("blocked device forwarded acknowledge");

   a_reply_vector: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      slave_reply_oe_out |-> dal_oe_out && (dal_out == VECTOR_P))
      else $error("reply without vector on lines");

   a_vector_range: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      slave_reply_oe_out |-> (dal_out < dcvi_pkg::VEC_LIMIT) &&
         ((dal_out & dcvi_pkg::VEC_ALIGN_MASK) == 16'h0000))
      else $error("vector outside low range or misaligned");

   a_reply_released: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      $fell(din_s) && ce_in |=> !slave_reply_oe_out && !dal_oe_out)
      else $error("reply or vector held after strobe release");

   a_reply_not_late: assert property (
      @(posedge ref_clk_in) disable iff (rst_in)
      !reply_late_out)
      else $error("reply deadline exceeded");
endmodule : dcvi_top
`default_nettype wire

// ==== testbench/dcvi_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcvi_cpu_model (
   input  wire logic        ref_clk_in,
   input  wire logic        go_in,
   input  wire logic        reply_in,
   input  wire logic [15:0] dal_in,
   output logic             strobe_out,
   output logic             ack_out,
   output logic [15:0]      vec_out,
   output logic             done_out
);
   int n;
   logic [15:0] stk [2];
   logic [15:0] pc_r = 16'h1000;
   logic [15:0] ps_r = 16'h0000;
   initial begin
      {strobe_out, ack_out, done_out, vec_out} = '0;
      forever begin
         @(negedge ref_clk_in);
         if (go_in) begin
            strobe_out = 1'b1;
            repeat (30) @(negedge ref_clk_in);
            ack_out = 1'b1;
            for (n = 0; n < 2100 && !reply_in; n++) @(posedge ref_clk_in);
            repeat (26) @(posedge ref_clk_in);
            vec_out = reply_in ? dal_in : 16'hffff;
            stk[0] = pc_r;
            stk[1] = ps_r;
            @(negedge ref_clk_in);
            {strobe_out, ack_out} = 2'h0;
            done_out = 1'b1;
            pc_r = stk[0];
            ps_r = stk[1];
            wait (!go_in);
            done_out = 1'b0;
         end
      end
   end
endmodule : dcvi_cpu_model
`default_nettype wire

// ==== testbench/dcvi_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcvi_top_tb;
   localparam logic [15:0] VEC = 16'h0100;
   logic clk = 0, rst = 1, en = 0, rdy = 0, go = 0, fwd = 0, sl = 0, oebad = 0;
   logic [1:0] lv = 0;
   logic [3:0] oth = 0, x;
   logic [3:0] tbl [4] = '{4'h1, 4'h3, 4'h5, 4'hd};
   int bad_count = 0, samples_checked = 0, k;
   wire logic stb, ack, rply, aco, dne, doe, late;
   wire logic [3:0] oe;
   wire logic [15:0] dal, vec;
   always #2.5 clk = ~clk;
   dcvi_top #(.VECTOR_P(VEC)) uut (.ref_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .cond_ready_in(rdy),
      .cond_done_in(1'b0), .cond_error_in(1'b0), .int_enable_in(en), .level_in(lv), .single_level_in(sl),
      .irq_lines_in(oe | oth), .data_input_strobe_in(stb), .ack_chain_in(ack), .irq_line_oe_out(oe),
      .ack_chain_out(aco), .slave_reply_oe_out(rply), .dal_out(dal), .dal_oe_out(doe), .reply_late_out(late));
   dcvi_cpu_model cpu (.ref_clk_in(clk), .go_in(go), .reply_in(rply), .dal_in(dal), .strobe_out(stb),
      .ack_out(ack), .vec_out(vec), .done_out(dne));
   always @(posedge clk) if (ack && aco) fwd <= 1'b1;
   always @(posedge clk) if (rply !== doe) oebad <= 1'b1;
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic serve(logic [1:0] l, logic [3:0] o, logic e, logic lose);
      lv = l; oth = o; en = e; rdy = 1; fwd = 0;
      x = e ? tbl[l] : 4'h0;
      repeat (10) @(negedge clk);
      chk("lines", {12'h0, x}, {12'h0, oe});
      rdy = 0;
      go = 1;
      for (k = 0; k < 2300 && !dne; k++) @(negedge clk);
      go = 0;
      repeat (10) @(negedge clk);
      chk("fwd", {15'h0, lose}, {15'h0, fwd});
      if (!lose) chk("vec", VEC, vec);
      chk("late", 16'h0, {15'h0, late});
      chk("dal oe", 16'h0, {15'h0, oebad});
      chk("after", lose ? {12'h0, x} : 16'h0, {12'h0, oe});
      $display("test lvl %0d lose %0d end", l, lose);
   endtask : serve
   initial begin
      repeat (12) @(negedge clk);
      rst = 0;
      serve(0, 0, 0, 1);
      for (int i = 0; i < 4; i++) serve(i[1:0], 0, 1, 0);
      serve(0, 4'h4, 1, 1);
      serve(0, 0, 1, 0);
      serve(2, 4'h8, 1, 1);
      serve(2, 4'h2, 1, 0);
      sl = 1;
      serve(0, 4'h4, 1, 0);
      serve(0, 0, 0, 1);
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule : dcvi_top_tb
`default_nettype wire
